// ===== include/aab_pkg.sv
// Summary of operation
// - Bit set/clear on low eight bits of modules 0h-5h and module 8h.
// - Bit set/clear on a 16-bit register keeps its upper byte unchanged.
// - Unsupported target gets prefix in high byte, bit mask in low byte.
// - Copy a low-eight bit of any register, or any active bit, to carry.
// - Arithmetic unit and all accumulators share one width; sixteen provided.
// - Low four index bits select the active accumulator out of sixteen.
// - Active accumulator is a read/write alias and the implicit destination.
// - Enabled stepping follows arithmetic, logic, shift, swap and acc moves.
// - No-step alias reads the active accumulator without stepping the index.
// - Step control bits 2:0 pick the modulo range, bit 6 the direction.
// - Modulo step changes only the selected low index bits, wrapping.
// - Two-operand ops with register or immediate source write accumulator.
// - Compare sets equals on a match and leaves the accumulator alone.
// - Single-operand invert, negate, rotates and shifts by one, two or four.
// - Logical right shift moves bit 0 to carry and clears the top bit.
// - Nibble swap within each byte; byte swap on the 16-bit variant.
// - Prefix defaults to zero for the high immediate byte.
package aab_pkg;
   localparam int DW      = 16;
   localparam int ACC_NUM = 16;
   localparam int IW      = 4;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_INDEX  = 8'h00;
   localparam logic [7:0] OFF_STEP   = 8'h04;
   localparam logic [7:0] OFF_PREFIX = 8'h08;
   localparam logic [7:0] OFF_DATA   = 8'h0c;
   localparam logic [7:0] OFF_CMD    = 8'h10;
   localparam logic [7:0] OFF_ACC    = 8'h14;
   localparam logic [7:0] OFF_RESULT = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;

   localparam logic [7:0] INDEX_RST  = 8'h00;
   localparam logic [7:0] STEP_RST   = 8'h00;
   localparam logic [7:0] PREFIX_RST = 8'h00;
   localparam logic [7:0] STEP_WMASK = 8'h47;
   localparam int         STEP_DIR   = 6;
   localparam logic [2:0] RANGE_STEP_RANGE_BIT2  = 3'b001;
   localparam logic [2:0] RANGE_MOD4  = 3'b010;
   localparam logic [2:0] RANGE_MOD8  = 3'b011;
   localparam logic [2:0] RANGE_MOD16 = 3'b100;
   localparam int         STS_EQ    = 0;
   localparam int         STS_CARRY = 1;
   localparam int         STS_ERR   = 2;
   localparam logic [3:0] MOD_PERIPH_MAX = 4'h5;
   localparam logic [3:0] MOD_SYS        = 4'h8;

   // ****************************************
   // Operations and states
   // ****************************************
   typedef enum logic [4:0] {
      OP_ADD   = 5'b00000, OP_ADDC  = 5'b00001, OP_SUB   = 5'b00010,
      OP_SUBB  = 5'b00011, OP_CMP   = 5'b00100, OP_AND   = 5'b00101,
      OP_OR    = 5'b00110, OP_XOR   = 5'b00111, OP_CPL   = 5'b01000,
      OP_NEG   = 5'b01001, OP_RL    = 5'b01010, OP_RLC   = 5'b01011,
      OP_RR    = 5'b01100, OP_RRC   = 5'b01101, OP_SLA   = 5'b01110,
      OP_SLA2  = 5'b01111, OP_SLA4  = 5'b10000, OP_SRA   = 5'b10001,
      OP_SRA2  = 5'b10010, OP_SRA4  = 5'b10011, OP_SHR   = 5'b10100,
      OP_XCHN  = 5'b10101, OP_XCH   = 5'b10110, OP_MVIN  = 5'b10111,
      OP_MVOUT = 5'b11000, OP_ALIAS = 5'b11001, OP_RECIRC = 5'b11010,
      OP_BSET  = 5'b11011, OP_BCLR  = 5'b11100, OP_RBITC = 5'b11101,
      OP_ABITC = 5'b11110, OP_NOP   = 5'b11111
   } aab_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_FETCH = 2'b01, ST_EXEC = 2'b10, ST_ACK = 2'b11
   } aab_state_t;

   typedef struct packed {
      logic [7:0]  rsv2;
      logic [3:0]  srcIdx;
      logic        rsv1;
      logic        supp;
      logic        imm;
      logic        srcAcc;
      logic [3:0]  modNum;
      logic [3:0]  bitNum;
      logic [2:0]  rsv0;
      aab_op_t     op;
   } aab_cmd_t;

   typedef struct packed {
      logic [DW-1:0] result;
      logic          wrAcc;
      logic          wrCarry;
      logic          carry;
      logic          wrEqual;
      logic          equal;
      logic          step;
   } aab_alu_t;
endpackage : aab_pkg

// ===== hdl/aab_acc_bank.sv
`timescale 1ns/10ps
module aab_acc_bank
   import aab_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic [IW-1:0] rdAddrA,
   input  wire logic [IW-1:0] rdAddrB,
   input  wire logic          we,
   input  wire logic [IW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   output logic      [DW-1:0] rdDataA,
   output logic      [DW-1:0] rdDataB
);
   logic [DW-1:0] mem [ACC_NUM];

   // ****************************************
   // Storage, one word per accumulator
   // ****************************************
   for (genvar g = 0; g < ACC_NUM; g++) begin : g_word
      always_ff @(posedge clk) begin
         if (reset)
            mem[g] <= '0;
         else if (we && wrAddr == IW'(g))
            mem[g] <= wrData;
      end
   end

   // Registered reads keep the bank a plain synchronous memory
   always_ff @(posedge clk) begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
   end
endmodule : aab_acc_bank

// ===== hdl/aab_alu.sv
`timescale 1ns/10ps
module aab_alu
   import aab_pkg::*;
(
   input  wire aab_op_t       op,
   input  wire logic [DW-1:0] acc,
   input  wire logic [DW-1:0] src,
   input  wire logic          carryIn,
   input  wire logic [3:0]    bitNum,
   output aab_alu_t           res
);
   logic          cin;
   logic [DW:0]   addSum;
   logic [DW:0]   subDif;
   logic [DW-1:0] nibSwap;

   assign cin    = (op == OP_ADDC || op == OP_SUBB) && carryIn;
   assign addSum = {1'b0, acc} + {1'b0, src} + {{DW{1'b0}}, cin};
   assign subDif = {1'b0, acc} - {1'b0, src} - {{DW{1'b0}}, cin};

   for (genvar g = 0; g < DW / 8; g++) begin : g_nib
      assign nibSwap[g*8 +: 8] = {acc[g*8 +: 4], acc[g*8+4 +: 4]};
   end

   always_comb begin
      res        = '0;
      res.result = acc;
      res.carry  = carryIn;
      res.wrAcc  = 1'b1;
      res.step   = 1'b1;
      case (op)
         OP_ADD, OP_ADDC: begin
            res.result  = addSum[DW-1:0];
            res.wrCarry = 1'b1;
            res.carry   = addSum[DW];
         end
         OP_SUB, OP_SUBB: begin
            res.result  = subDif[DW-1:0];
            res.wrCarry = 1'b1;
            res.carry   = subDif[DW];
         end
         OP_CMP: begin
            res.wrAcc   = 1'b0;
            res.step    = 1'b0;
            res.wrEqual = 1'b1;
            res.equal   = (acc == src);
         end
         OP_AND: res.result = acc & src;
         OP_OR:  res.result = acc | src;
         OP_XOR: res.result = acc ^ src;
         OP_CPL: res.result = ~acc;
         OP_NEG: res.result = ~acc + 1'b1;
         OP_RL:  res.result = {acc[DW-2:0], acc[DW-1]};
         OP_RR:  res.result = {acc[0], acc[DW-1:1]};
         OP_RLC: begin
            res.result  = {acc[DW-2:0], carryIn};
            res.wrCarry = 1'b1;
            res.carry   = acc[DW-1];
         end
         OP_RRC: begin
            res.result  = {carryIn, acc[DW-1:1]};
            res.wrCarry = 1'b1;
            res.carry   = acc[0];
         end
         OP_SLA, OP_SLA2, OP_SLA4: begin
            res.wrCarry = 1'b1;
            res.result  = (op == OP_SLA) ? acc << 1 :
                          (op == OP_SLA2) ? acc << 2 : acc << 4;
            res.carry   = (op == OP_SLA) ? acc[DW-1] :
                          (op == OP_SLA2) ? acc[DW-2] : acc[DW-4];
         end
         OP_SRA, OP_SRA2, OP_SRA4: begin
            res.wrCarry = 1'b1;
            res.result  = (op == OP_SRA) ? DW'($signed(acc) >>> 1) :
                          (op == OP_SRA2) ? DW'($signed(acc) >>> 2) :
                          DW'($signed(acc) >>> 4);
            res.carry   = (op == OP_SRA) ? acc[0] :
                          (op == OP_SRA2) ? acc[1] : acc[3];
         end
         OP_SHR: begin
            res.result  = {1'b0, acc[DW-1:1]};
            res.wrCarry = 1'b1;
            res.carry   = acc[0];
         end
         OP_XCHN:   res.result = nibSwap;
         OP_XCH:    res.result = {acc[7:0], acc[DW-1:8]};
         OP_MVIN:   res.result = src;
         OP_RECIRC: res.result = acc;
         OP_MVOUT:  res.wrAcc  = 1'b0;
         OP_ALIAS: begin
            res.wrAcc = 1'b0;
            res.step  = 1'b0;
         end
         OP_ABITC: begin
            res.wrAcc   = 1'b0;
            res.step    = 1'b0;
            res.wrCarry = 1'b1;
            res.carry   = acc[bitNum];
         end
         default: begin
            res.wrAcc = 1'b0;
            res.step  = 1'b0;
         end
      endcase
   end
endmodule : aab_alu

// ===== hdl/aab_top.sv
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module aab_top
   import aab_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic             carryFlag,
   output logic             equalFlag
);
   // ****************************************
   // State and registers
   // ****************************************
   aab_state_t    state;
   aab_state_t    next_state;
   logic [7:0]    accIndex;
   logic [7:0]    stepCtrl;
   logic [7:0]    prefix;
   logic [DW-1:0] dataReg;
   logic [DW-1:0] resultReg;
   logic          errFlag;
   aab_alu_t      aluQ;
   aab_alu_t      aluRes;
   logic [DW-1:0] rdDataA;
   logic [DW-1:0] rdDataB;

   // ****************************************
   // Bus decode
   // ****************************************
   aab_cmd_t      cmdIn;
   logic [5:0]    wordAddr;
   logic [31:0]   laneMask;
   logic          hitIndex, hitStep, hitPrefix, hitData;
   logic          hitCmd, hitAcc, hitResult, hitStatus;
   logic          commit;
   logic          cmdGo;
   logic [DW-1:0] wr16;
   logic [7:0]    wr8;
   logic [31:0]   rdMux;

   assign cmdIn     = aab_cmd_t'(writedata);
   assign wordAddr  = address[7:2];
   assign laneMask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign hitIndex  = wordAddr == OFF_INDEX[7:2];
   assign hitStep   = wordAddr == OFF_STEP[7:2];
   assign hitPrefix = wordAddr == OFF_PREFIX[7:2];
   assign hitData   = wordAddr == OFF_DATA[7:2];
   assign hitCmd    = wordAddr == OFF_CMD[7:2];
   assign hitAcc    = wordAddr == OFF_ACC[7:2];
   assign hitResult = wordAddr == OFF_RESULT[7:2];
   assign hitStatus = wordAddr == OFF_STATUS[7:2];
   assign commit    = state == ST_ACK && write;
   assign cmdGo     = commit && hitCmd;
   assign wr8       = byteenable[0] ? writedata[7:0] : 8'h00;

   // ****************************************
   // Source selection and bit operations
   // ****************************************
   logic [DW-1:0] srcVal;
   logic [DW-1:0] accOld;
   logic          isBitOp;
   logic          modOk;
   logic [7:0]    bitMask;
   logic [7:0]    maskByte;
   logic [7:0]    lowNew;
   logic [DW-1:0] bitVal;
   logic          regBit;
   logic          cmpHit;

   assign accOld   = rdDataA;
   assign srcVal   = cmdIn.imm ? {prefix, dataReg[7:0]} :
                     cmdIn.srcAcc ? rdDataB : dataReg;
   assign isBitOp  = cmdIn.op == OP_BSET || cmdIn.op == OP_BCLR;
   assign modOk    = cmdIn.modNum <= MOD_PERIPH_MAX ||
                     cmdIn.modNum == MOD_SYS;
   assign bitMask  = 8'h01 << cmdIn.bitNum[2:0];
   assign maskByte = cmdIn.op == OP_BSET ? bitMask : ~bitMask;
   assign lowNew   = cmdIn.op == OP_BSET ? dataReg[7:0] | bitMask :
                                           dataReg[7:0] & ~bitMask;
   assign bitVal   = cmdIn.supp ? {dataReg[DW-1:8], lowNew} :
                                  {prefix, maskByte};
   assign regBit   = dataReg[cmdIn.bitNum[2:0]];
   assign cmpHit   = srcVal == accOld;
   assign wr16     = (dataReg & ~laneMask[DW-1:0]) |
                     (writedata[DW-1:0] & laneMask[DW-1:0]);

   // ****************************************
   // Index stepping
   // ****************************************
   logic [2:0] stepRange;
   logic [3:0] stepMask;
   logic [3:0] stepMoved;
   logic [3:0] stepNext;

   assign stepRange = stepCtrl[2:0];
   assign stepMask  = stepRange == RANGE_STEP_RANGE_BIT2  ? 4'h1 :
                      stepRange == RANGE_MOD4  ? 4'h3 :
                      stepRange == RANGE_MOD8  ? 4'h7 :
                      stepRange == RANGE_MOD16 ? 4'hf : 4'h0;
   assign stepMoved = stepCtrl[STEP_DIR] ? accIndex[3:0] - 4'h1 :
                                           accIndex[3:0] + 4'h1;
   assign stepNext  = (accIndex[3:0] & ~stepMask) |
                      (stepMoved & stepMask);

   // ****************************************
   // Accumulator bank and ALU
   // ****************************************
   logic          bankWe;
   logic [DW-1:0] bankWrData;

   // Plain byte-lane merge is skipped for the alias: a word write is assumed
   assign bankWe     = (cmdGo && aluQ.wrAcc) || (commit && hitAcc);
   assign bankWrData = hitAcc ? writedata[DW-1:0] : aluQ.result;

   aab_acc_bank u_bank (
      .clk     (clk),
      .reset   (reset),
      .rdAddrA (accIndex[3:0]),
      .rdAddrB (cmdIn.srcIdx),
      .we      (bankWe),
      .wrAddr  (accIndex[3:0]),
      .wrData  (bankWrData),
      .rdDataA (rdDataA),
      .rdDataB (rdDataB)
   );

   aab_alu u_alu (
      .op      (cmdIn.op),
      .acc     (accOld),
      .src     (srcVal),
      .carryIn (carryFlag),
      .bitNum  (cmdIn.bitNum),
      .res     (aluRes)
   );

   // ****************************************
   // Bus handshake
   // ****************************************
   // Fixed four-cycle answer; the bank read latency sets the pace
   always_comb begin
      case (state)
         ST_IDLE:  next_state = (read || write) ? ST_FETCH : ST_IDLE;
         ST_FETCH: next_state = ST_EXEC;
         ST_EXEC:  next_state = ST_ACK;
         ST_ACK:   next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   assign rdMux = hitIndex  ? {24'h0, accIndex} :
                  hitStep   ? {24'h0, stepCtrl} :
                  hitPrefix ? {24'h0, prefix} :
                  hitData   ? {16'h0, dataReg} :
                  hitAcc    ? {16'h0, accOld} :
                  hitResult ? {16'h0, resultReg} :
                  hitStatus ? {29'h0, errFlag, carryFlag, equalFlag} :
                  32'h0;

   always_ff @(posedge clk) begin
      if (reset) begin
         state       <= ST_IDLE;
         waitrequest <= 1'b1;
         readdata    <= 32'h0;
         aluQ        <= '0;
      end else begin
         state       <= next_state;
         waitrequest <= next_state != ST_ACK;
         if (state == ST_EXEC) begin
            aluQ <= aluRes;
            if (read)
               readdata <= rdMux;
         end
      end
   end

   // ****************************************
   // Register updates at the answering edge
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         accIndex <= INDEX_RST;
         stepCtrl <= STEP_RST;
         prefix   <= PREFIX_RST;
         dataReg  <= '0;
      end else begin
         if (commit && hitIndex)
            accIndex <= wr8;
         else if (cmdGo && aluQ.step)
            accIndex <= {accIndex[7:4], stepNext};
         if (commit && hitStep)
            stepCtrl <= wr8 & STEP_WMASK;
         // Prefix lives for one command only, then falls back to zero
         if (commit && hitPrefix)
            prefix <= wr8;
         else if (cmdGo)
            prefix <= PREFIX_RST;
         if (commit && hitData)
            dataReg <= wr16;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         resultReg <= '0;
         carryFlag <= 1'b0;
         equalFlag <= 1'b0;
         errFlag   <= 1'b0;
      end else begin
         if (cmdGo && (cmdIn.op == OP_MVOUT || cmdIn.op == OP_ALIAS))
            resultReg <= aluQ.result;
         else if (cmdGo && isBitOp && modOk)
            resultReg <= bitVal;
         if (commit && hitStatus)
            carryFlag <= wr8[STS_CARRY];
         else if (cmdGo && cmdIn.op == OP_RBITC)
            carryFlag <= regBit;
         else if (cmdGo && aluQ.wrCarry)
            carryFlag <= aluQ.carry;
         if (commit && hitStatus)
            equalFlag <= wr8[STS_EQ];
         else if (cmdGo && aluQ.wrEqual)
            equalFlag <= aluQ.equal;
         if (cmdGo && isBitOp && !modOk)
            errFlag <= 1'b1;
         else if (commit && hitStatus)
            errFlag <= wr8[STS_ERR];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_req;
      state == ST_IDLE && (read || write);
   endsequence
   sequence s_ans;
      waitrequest [*2] ##1 !waitrequest ##1 waitrequest;
   endsequence

   property p_answer;
      s_req |=> s_ans;
   endproperty
   a_answer: assert property (p_answer)
      else $error("answer not on third cycle");

   property p_reset;
      @(posedge clk) disable iff (1'b0)
      reset |=> accIndex == 8'h00 && stepCtrl == 8'h00;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset state wrong");

   property p_step4;
      cmdGo && aluQ.step && stepCtrl == 8'h02 |=>
         accIndex[1:0] == $past(accIndex[1:0]) + 2'd1 &&
         accIndex[7:2] == $past(accIndex[7:2]);
   endproperty
   a_step4: assert property (p_step4)
      else $error("modulo 4 increment wrong");

   property p_step16dec;
      cmdGo && aluQ.step && stepCtrl == 8'h44 |=>
         accIndex[3:0] == $past(accIndex[3:0]) - 4'd1;
   endproperty
   a_step16dec: assert property (p_step16dec)
      else $error("modulo 16 decrement wrong");

   property p_nostep;
      cmdGo && stepCtrl[2:0] == 3'b000 |=> $stable(accIndex);
   endproperty
   a_nostep: assert property (p_nostep)
      else $error("index moved while stepping off");

   property p_alias;
      cmdGo && cmdIn.op == OP_ALIAS |=>
         $stable(accIndex) && resultReg == $past(rdDataA);
   endproperty
   a_alias: assert property (p_alias)
      else $error("alias read stepped or lost data");

   property p_bitset;
      cmdGo && cmdIn.op == OP_BSET && cmdIn.supp && modOk |=>
         resultReg == ($past(dataReg) | {8'h00, $past(bitMask)});
   endproperty
   a_bitset: assert property (p_bitset)
      else $error("bit set disturbed register");

   property p_bitclr;
      cmdGo && cmdIn.op == OP_BCLR && !cmdIn.supp && modOk |=>
         resultReg == {$past(prefix), ~$past(bitMask)};
   endproperty
   a_bitclr: assert property (p_bitclr)
      else $error("unsupported clear pattern wrong");

   property p_badmod;
      cmdGo && isBitOp && !modOk |=> errFlag && $stable(resultReg);
   endproperty
   a_badmod: assert property (p_badmod)
      else $error("bad module accepted");

   property p_cmp;
      cmdGo && cmdIn.op == OP_CMP |-> !bankWe ##1 equalFlag == $past(cmpHit);
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("compare wrong");

   property p_shr;
      cmdGo && cmdIn.op == OP_SHR |->
         !bankWrData[DW-1] ##1 carryFlag == $past(accOld[0]);
   endproperty
   a_shr: assert property (p_shr)
      else $error("logical shift right wrong");

   property p_prefix;
      cmdGo |=> prefix == 8'h00;
   endproperty
   a_prefix: assert property (p_prefix)
      else $error("prefix not back to zero");
endmodule : aab_top

// ===== sim/aab_host.sv
`timescale 1ns/10ps
// ********
// Bus master
// ********
module aab_host (
   input  wire logic        clk,
   output logic      [7:0]  address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata,
   output logic      [3:0]  byteenable,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest
);
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
   end

   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic ok);
      int n;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      read      <= !wr;
      write     <= wr;
      ok = 1'b0;
      q = 32'h0;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) begin
            ok = 1'b1;
            q = readdata;
         end
      end
      // Released lines change so no stale value is trusted
      read      <= 1'b0;
      write     <= 1'b0;
      address   <= ~a;
      writedata <= ~d;
   endtask : xfer
endmodule : aab_host

// ===== sim/test_accumulator_alu_bit_ops.sv
`timescale 1ns/10ps
// ********
// Bench
// ********
module test_accumulator_alu_bit_ops
   import aab_pkg::*;
();
   logic        clk;
   logic        reset;
   logic [7:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        carryFlag;
   logic        equalFlag;
   logic [31:0] q;
   int          n_errors;
   int          tests_run;

   aab_top uut (.clk, .reset, .address, .read, .write, .writedata,
                .byteenable, .readdata, .waitrequest, .carryFlag,
                .equalFlag);
   aab_host host (.clk, .address, .read, .write, .writedata, .byteenable,
                  .readdata, .waitrequest);

   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      logic ok;
      host.xfer(wr, a, d, q, ok);
      if (!ok) begin
         n_errors++;
         stop_test();
      end
   endtask : bus

   // Source is DATA, never the active accumulator itself
   function automatic logic [31:0] cmd(aab_op_t op, logic [3:0] b = 4'h0,
                                       logic [3:0] m = 4'h8, logic s = 1'b0);
      return {13'h0000, s, 2'b00, m, b, 3'b000, op};
   endfunction : cmd

   task automatic t_reset();
      bus(0, OFF_INDEX, 32'h0);
      chk("index", q, 32'h0);
      bus(0, OFF_STEP, 32'h0);
      chk("step", q, 32'h0);
      bus(0, OFF_PREFIX, 32'h0);
      chk("prefix", q, 32'h0);
      bus(1, OFF_STEP, 32'hff);
      bus(0, OFF_STEP, 32'h0);
      chk("stepmask", q, 32'h47);
      bus(0, 8'h20, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask : t_reset

   task automatic t_modulo();
      logic [15:0] acc[4] = '{16'h3, 16'h4, 16'h6, 16'h2};
      bus(1, OFF_STEP, 32'h02);
      bus(1, OFF_INDEX, 32'h02);
      for (int k = 1; k <= 5; k++) begin
         bus(1, OFF_DATA, 32'(k));
         bus(1, OFF_CMD, cmd(OP_ADD));
         bus(0, OFF_INDEX, 32'h0);
         chk("index", q, 32'((k + 2) % 4));
      end
      bus(1, OFF_STEP, 32'h00);
      for (int i = 0; i < 4; i++) begin
         bus(1, OFF_INDEX, 32'(i));
         bus(0, OFF_ACC, 32'h0);
         chk("acc", q, {16'h0, acc[i]});
      end
   endtask : t_modulo

   task automatic t_steps();
      logic [23:0] t[9] = '{24'h00a5a5, 24'h01a5a4, 24'h41a6a7,
         24'h02a3a0, 24'h42a4a7, 24'h03a7a0, 24'h43a8af, 24'h04afa0,
         24'h44a0af};
      for (int i = 0; i < 9; i++) begin
         bus(1, OFF_STEP, 32'(t[i][23:16]));
         bus(1, OFF_INDEX, 32'(t[i][15:8]));
         bus(1, OFF_CMD, cmd(OP_CPL));
         bus(0, OFF_INDEX, 32'h0);
         chk("step", q, 32'(t[i][7:0]));
      end
   endtask : t_steps

   task automatic t_cmp();
      bus(1, OFF_STEP, 32'h04);
      bus(1, OFF_INDEX, 32'h03);
      bus(1, OFF_ACC, 32'h1234);
      bus(1, OFF_DATA, 32'h1234);
      bus(1, OFF_CMD, cmd(OP_CMP));
      bus(0, OFF_STATUS, 32'h0);
      chk("eq", {31'h0, equalFlag}, 32'h1);
      bus(0, OFF_ACC, 32'h0);
      chk("acc", q, 32'h1234);
      bus(1, OFF_CMD, cmd(OP_ALIAS));
      bus(0, OFF_RESULT, 32'h0);
      chk("alias", q, 32'h1234);
      bus(0, OFF_INDEX, 32'h0);
      chk("index", q, 32'h03);
      bus(1, OFF_CMD, cmd(OP_MVOUT));
      bus(0, OFF_INDEX, 32'h0);
      chk("index", q, 32'h04);
   endtask : t_cmp

   task automatic t_single();
      logic [39:0] t[16] = '{40'h0e80010002, 40'h0b00010003,
         40'h0d00010000, 40'h0f40010004, 40'h128004e001, 40'h138010f801,
         40'h1a12341234, 40'h081234edcb, 40'h090001ffff,
         40'h0a80010003, 40'h0c00018000, 40'h1012342340, 40'h118002c001,
         40'h1512342143, 40'h1612343412, 40'h1480014000};
      bus(1, OFF_STEP, 32'h00);
      for (int i = 0; i < 16; i++) begin
         bus(1, OFF_ACC, 32'(t[i][31:16]));
         bus(1, OFF_CMD, cmd(aab_op_t'(t[i][36:32])));
         bus(0, OFF_ACC, 32'h0);
         chk("acc", q, 32'(t[i][15:0]));
      end
      bus(0, OFF_STATUS, 32'h0);
      chk("carry", {30'h0, q[1], carryFlag}, 32'h3);
   endtask : t_single

   task automatic t_alu2();
      logic [55:0] t[8] = '{56'h00ffff00010000, 56'h01000100010003,
         56'h0200010002ffff, 56'h03000500010003, 56'h0500ff0f0f000f,
         56'h0600f00f000ff0, 56'h0700ff0f0f0ff0, 56'h171234abcdabcd};
      for (int i = 0; i < 8; i++) begin
         bus(1, OFF_ACC, 32'(t[i][47:32]));
         bus(1, OFF_DATA, 32'(t[i][31:16]));
         bus(1, OFF_CMD, cmd(aab_op_t'(t[i][52:48])));
         bus(0, OFF_ACC, 32'h0);
         chk("alu", q, 32'(t[i][15:0]));
      end
      bus(1, OFF_PREFIX, 32'h12);
      bus(1, OFF_DATA, 32'h0034);
      bus(1, OFF_CMD, cmd(OP_MVIN) | 32'h20000);
      bus(0, OFF_ACC, 32'h0);
      chk("imm", q, 32'h1234);
      bus(1, OFF_DATA, 32'h0056);
      bus(1, OFF_CMD, cmd(OP_MVIN) | 32'h20000);
      bus(0, OFF_ACC, 32'h0);
      chk("imm0", q, 32'h0056);
      bus(1, OFF_INDEX, 32'h05);
      bus(1, OFF_ACC, 32'h0001);
      bus(1, OFF_INDEX, 32'h04);
      bus(1, OFF_CMD, cmd(OP_ADD) | 32'h510000);
      bus(0, OFF_ACC, 32'h0);
      chk("srcacc", q, 32'h0057);
   endtask : t_alu2

   task automatic t_bits();
      bus(1, OFF_DATA, 32'hab00);
      bus(1, OFF_CMD, cmd(OP_BSET, 4'h7, 4'h8, 1'b1));
      bus(0, OFF_RESULT, 32'h0);
      chk("bset", q, 32'hab80);
      // Prefix loaded ahead of the command that uses it
      bus(1, OFF_PREFIX, 32'h5a);
      bus(1, OFF_CMD, cmd(OP_BCLR, 4'h2, 4'h5));
      bus(0, OFF_RESULT, 32'h0);
      chk("bclr", q, 32'h5afb);
      bus(1, OFF_CMD, cmd(OP_BSET, 4'h1, 4'h6, 1'b1));
      bus(0, OFF_STATUS, 32'h0);
      chk("err", 32'(q[2]), 32'h1);
      bus(1, OFF_DATA, 32'h0020);
      bus(1, OFF_CMD, cmd(OP_RBITC, 4'h5, 4'h9));
      bus(0, OFF_STATUS, 32'h0);
      chk("rbit", 32'(q[1]), 32'h1);
      bus(1, OFF_CMD, cmd(OP_RBITC, 4'h4, 4'h9));
      bus(0, OFF_STATUS, 32'h0);
      chk("rbit", 32'(q[1]), 32'h0);
      bus(1, OFF_ACC, 32'h8000);
      bus(1, OFF_CMD, cmd(OP_ABITC, 4'hf));
      bus(0, OFF_STATUS, 32'h0);
      chk("abit", 32'(q[1]), 32'h1);
   endtask : t_bits

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      reset = 1'b1;
      n_errors = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_modulo();
      t_steps();
      t_cmp();
      t_single();
      t_alu2();
      t_bits();
      stop_test();
   end
endmodule : test_accumulator_alu_bit_ops
